// *** src/wrs_pkg.sv ***
// constants shared by the watchdog reset supervisor
package wrs_pkg;
    // ------------------------------------------------
    // bus
    // ------------------------------------------------
    localparam int          AXI_AW      = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // ------------------------------------------------
    // register offsets
    // ------------------------------------------------
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_HOLD     = 8'h04;
    localparam logic [7:0]  OFS_PERIOD   = 8'h08;
    localparam logic [7:0]  OFS_STATUS   = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0]  OFS_IRQ_CLR  = 8'h14;
    localparam logic [7:0]  OFS_IRQ_EN   = 8'h18;
    // ------------------------------------------------
    // fields and timing
    // ------------------------------------------------
    localparam int          CTRL_WIN_BIT = 0;
    localparam int          IRQ_W        = 3;
    localparam int          EV_SUPPLY    = 0;
    localparam int          EV_TIMEOUT   = 1;
    localparam int          EV_FAST      = 2;
    localparam int          EXT_SHIFT    = 7;
    localparam int          SH_R8        = 3;
    localparam int          SH_R16       = 4;
    localparam int          SH_R64       = 6;
    localparam int          CNT_W        = 32;
    localparam int          WD_W         = CNT_W + EXT_SHIFT;
    localparam int          PIN_W        = 7;
    // pin order: kick, mr_n, supply low, ext low, ext sel, a, b
    localparam logic [6:0]  PIN_INIT     = 7'h60;
    typedef enum logic {WRS_HOLD, WRS_RUN} wrs_state_e;
endpackage : wrs_pkg

// *** src/wrs_supervisor.sv ***
// watchdog reset supervisor with axi4-lite registers
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module wrs_supervisor #(
    parameter logic [31:0] P_HOLD_INIT   = 32'h0000_00c8,
    parameter logic [31:0] P_PERIOD_INIT = 32'h0000_03e8
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst_b,
    input  wire logic                       i_kick_input,
    input  wire logic                       i_manual_reset_n,
    input  wire logic                       i_supply_low,
    input  wire logic                       i_ext_monitor_low,
    input  wire logic                       i_extended_period_select,
    input  wire logic                       i_ratio_select_a,
    input  wire logic                       i_ratio_select_b,
    output logic                            o_reset_n,
    output logic                            o_irq,
    input  wire logic [wrs_pkg::AXI_AW-1:0] i_s_axi_awaddr,
    input  wire logic                       i_s_axi_awvalid,
    output logic                            o_s_axi_awready,
    input  wire logic [31:0]                i_s_axi_wdata,
    input  wire logic [3:0]                 i_s_axi_wstrb,
    input  wire logic                       i_s_axi_wvalid,
    output logic                            o_s_axi_wready,
    output logic [1:0]                      o_s_axi_bresp,
    output logic                            o_s_axi_bvalid,
    input  wire logic                       i_s_axi_bready,
    input  wire logic [wrs_pkg::AXI_AW-1:0] i_s_axi_araddr,
    input  wire logic                       i_s_axi_arvalid,
    output logic                            o_s_axi_arready,
    output logic [31:0]                     o_s_axi_rdata,
    output logic [1:0]                      o_s_axi_rresp,
    output logic                            o_s_axi_rvalid,
    input  wire logic                       i_s_axi_rready
);
    import wrs_pkg::*;

    // ------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------
    logic [PIN_W-1:0] pins_s;
    logic             kick_s;
    logic             mr_n_s;
    logic             sup_low_s;
    logic             ext_low_s;
    logic             xsel_s;
    logic             sel_a_s;
    logic             sel_b_s;

    wrs_sync #(
        .P_W    (PIN_W),
        .P_INIT (PIN_INIT)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   ({i_kick_input, i_manual_reset_n,
                     i_supply_low, i_ext_monitor_low,
                     i_extended_period_select,
                     i_ratio_select_a, i_ratio_select_b}),
        .o_sync    (pins_s)
    );

    assign {kick_s, mr_n_s, sup_low_s, ext_low_s,
            xsel_s, sel_a_s, sel_b_s} = pins_s;

    // ------------------------------------------------
    // registers and shared signals
    // ------------------------------------------------
    logic             win_r;
    logic [CNT_W-1:0] hold_r;
    logic [CNT_W-1:0] period_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] ev;
    wrs_state_e       state_r;
    logic [CNT_W-1:0] hold_cnt_r;
    logic [CNT_W-1:0] hold_m1;
    logic [WD_W-1:0]  wd_cnt_r;
    logic [WD_W-1:0]  lim_m1;
    logic [CNT_W-1:0] fast_lim;
    logic             kick_d_r;
    logic             xsel_d_r;
    logic             sel_a_d_r;
    logic             sel_b_d_r;
    logic             cond_d_r;
    logic             cond;
    logic             kick_fall;
    logic             wd_en;
    logic             cfg_chg;
    logic             running;
    logic             slow_hit;
    logic             fast_hit;
    logic             kick_ok;
    logic             wd_fault;

    // ------------------------------------------------
    // edge and change detection
    // ------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            kick_d_r  <= 1'b1;
            xsel_d_r  <= 1'b0;
            sel_a_d_r <= 1'b0;
            sel_b_d_r <= 1'b0;
            cond_d_r  <= 1'b0;
        end else begin
            kick_d_r  <= kick_s;
            xsel_d_r  <= xsel_s;
            sel_a_d_r <= sel_a_s;
            sel_b_d_r <= sel_b_s;
            cond_d_r  <= cond;
        end
    end

    assign kick_fall = kick_d_r && !kick_s;
    assign cond = sup_low_s || ext_low_s || !mr_n_s;

    // ------------------------------------------------
    // reset output sequencer
    // ------------------------------------------------
    // zero hold is treated as one cycle so a pulse always shows
    assign hold_m1 = (hold_r == '0) ? '0 : hold_r - 1'b1;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            state_r    <= WRS_HOLD;
            hold_cnt_r <= '0;
        end else if (cond || wd_fault) begin
            state_r    <= WRS_HOLD;
            hold_cnt_r <= '0;
        end else begin
            unique case (state_r)
                WRS_HOLD: begin
                    if (hold_cnt_r >= hold_m1) begin
                        state_r <= WRS_RUN;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 1'b1;
                    end
                end
                WRS_RUN: begin
                    hold_cnt_r <= '0;
                end
            endcase
        end
    end

    assign o_reset_n = (state_r == WRS_RUN);

    // ------------------------------------------------
    // watchdog
    // ------------------------------------------------
    always_comb begin
        unique case ({sel_a_s, sel_b_s})
            2'b00:   fast_lim = period_r >> SH_R8;
            2'b01:   fast_lim = period_r >> SH_R16;
            2'b11:   fast_lim = period_r >> SH_R64;
            default: fast_lim = '0;
        endcase
    end

    always_comb begin
        if (win_r) begin
            lim_m1  = {{EXT_SHIFT{1'b0}}, period_r} - 1'b1;
            wd_en   = (period_r != '0)
                      && !(sel_a_s && !sel_b_s);
            cfg_chg = (sel_a_s ^ sel_a_d_r)
                      || (sel_b_s ^ sel_b_d_r);
        end else begin
            lim_m1  = (xsel_s ? {period_r, {EXT_SHIFT{1'b0}}}
                       : {{EXT_SHIFT{1'b0}}, period_r})
                      - 1'b1;
            wd_en   = (period_r != '0);
            cfg_chg = xsel_s ^ xsel_d_r;
        end
    end

    // kicks only count while reset is released
    assign running  = wd_en && (state_r == WRS_RUN);
    assign slow_hit = running && (wd_cnt_r >= lim_m1);
    assign fast_hit = running && win_r && kick_fall
                      && (wd_cnt_r < {{EXT_SHIFT{1'b0}},
                                      fast_lim});
    assign kick_ok  = running && kick_fall && !fast_hit;
    // a config change clears the timer and wins over a fault
    assign wd_fault = !cfg_chg
                      && (fast_hit || (slow_hit && !kick_ok));

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            wd_cnt_r <= '0;
        end else if (!running || kick_ok || cfg_chg
                     || wd_fault || cond) begin
            wd_cnt_r <= '0;
        end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
        end
    end

    // ------------------------------------------------
    // interrupts
    // ------------------------------------------------
    always_comb begin
        ev             = '0;
        ev[EV_SUPPLY]  = cond && !cond_d_r;
        ev[EV_TIMEOUT] = wd_fault && !fast_hit;
        ev[EV_FAST]    = wd_fault && fast_hit;
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            irq_stat_r <= '0;
            o_irq      <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | ev;
            o_irq      <= |(irq_stat_r & irq_en_r);
        end
    end

    // ------------------------------------------------
    // axi4-lite write
    // ------------------------------------------------
    logic              aw_got_r;
    logic              w_got_r;
    logic [AXI_AW-1:0] waddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic [31:0]       wmask;
    logic [31:0]       wval;
    logic              wr_en;
    logic              wr_map;

    function automatic logic [31:0] strb_mask(
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strb_mask

    assign o_s_axi_awready = !aw_got_r && !o_s_axi_bvalid;
    assign o_s_axi_wready  = !w_got_r && !o_s_axi_bvalid;
    assign wr_en = aw_got_r && w_got_r && !o_s_axi_bvalid;
    assign wmask = strb_mask(wstrb_r);
    assign wval  = wdata_r & wmask;
    assign wr_map = (waddr_r == OFS_CTRL) || (waddr_r == OFS_HOLD)
                    || (waddr_r == OFS_PERIOD)
                    || (waddr_r == OFS_STATUS)
                    || (waddr_r == OFS_IRQ_STAT)
                    || (waddr_r == OFS_IRQ_CLR)
                    || (waddr_r == OFS_IRQ_EN);
    assign irq_clr = (wr_en && waddr_r == OFS_IRQ_CLR)
                     ? wval[IRQ_W-1:0] : '0;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            aw_got_r       <= 1'b0;
            w_got_r        <= 1'b0;
            waddr_r        <= '0;
            wdata_r        <= '0;
            wstrb_r        <= '0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_got_r <= 1'b1;
                waddr_r  <= {i_s_axi_awaddr[AXI_AW-1:2], 2'b00};
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= i_s_axi_wdata;
                wstrb_r <= i_s_axi_wstrb;
            end
            if (wr_en) begin
                aw_got_r       <= 1'b0;
                w_got_r        <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // cycle counts replace the timing capacitors
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            win_r    <= 1'b0;
            hold_r   <= P_HOLD_INIT;
            period_r <= P_PERIOD_INIT;
            irq_en_r <= '0;
        end else if (wr_en) begin
            if (waddr_r == OFS_CTRL && wstrb_r[0]) begin
                win_r <= wdata_r[CTRL_WIN_BIT];
            end
            if (waddr_r == OFS_HOLD) begin
                hold_r <= (hold_r & ~wmask) | wval;
            end
            if (waddr_r == OFS_PERIOD) begin
                period_r <= (period_r & ~wmask) | wval;
            end
            if (waddr_r == OFS_IRQ_EN && wstrb_r[0]) begin
                irq_en_r <= wdata_r[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------
    // axi4-lite read
    // ------------------------------------------------
    logic [AXI_AW-1:0] raddr;
    logic [31:0]       rmux;
    logic              rmap;

    assign o_s_axi_arready = !o_s_axi_rvalid;
    assign raddr = {i_s_axi_araddr[AXI_AW-1:2], 2'b00};

    always_comb begin
        rmux = '0;
        rmap = 1'b1;
        unique case (raddr)
            OFS_CTRL:     rmux[CTRL_WIN_BIT] = win_r;
            OFS_HOLD:     rmux = hold_r;
            OFS_PERIOD:   rmux = period_r;
            OFS_STATUS:   rmux[2:0] = {win_r, wd_en, !o_reset_n};
            OFS_IRQ_STAT: rmux[IRQ_W-1:0] = irq_stat_r;
            OFS_IRQ_CLR:  rmux = '0;
            OFS_IRQ_EN:   rmux[IRQ_W-1:0] = irq_en_r;
            default:      rmap = 1'b0;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= '0;
            o_s_axi_rresp  <= RESP_OKAY;
        end else if (i_s_axi_arvalid && o_s_axi_arready) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= rmux;
            o_s_axi_rresp  <= rmap ? RESP_OKAY : RESP_SLVERR;
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    logic [CNT_W-1:0] seen_r;

    // cycles of held reset since the last cause
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || cond || wd_fault) begin
            seen_r <= '0;
        end else if (!o_reset_n) begin
            seen_r <= seen_r + 1'b1;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    a_cond_asserts: assert property (
        cond |=> !o_reset_n)
        else $error("reset not asserted on fault");
    a_hold_length: assert property (
        $rose(o_reset_n) && $stable(hold_r)
        |-> seen_r == ((hold_r == '0) ? 1 : hold_r))
        else $error("reset hold length wrong");
    a_fault_pulse: assert property (
        wd_fault && !cond |=> !o_reset_n && seen_r == '0)
        else $error("watchdog fault gave no reset");
    a_timer_clear: assert property (
        !o_reset_n |-> wd_cnt_r == '0)
        else $error("timer runs during reset");
    a_zero_period: assert property (
        !win_r && period_r == '0 |-> !wd_fault)
        else $error("disabled watchdog faulted");
    a_basic_limit: assert property (
        !win_r && wd_fault |-> wd_cnt_r + 1'b1 == (xsel_s
            ? {period_r, 7'h00} : {7'h00, period_r}))
        else $error("basic timeout at wrong count");
    a_fast_fault: assert property (
        win_r && o_reset_n && kick_fall && wd_en && !cfg_chg
        && wd_cnt_r < {7'h00, fast_lim} |=> !o_reset_n)
        else $error("early kick not faulted");
    a_release_start: assert property (
        $rose(o_reset_n) |-> wd_cnt_r == '0)
        else $error("timer not clear at release");
    // a cause in the same cycle legally pulls reset low as well
    a_kick_restart: assert property (
        kick_ok && !cond |=> wd_cnt_r == '0 && o_reset_n)
        else $error("valid kick did not restart timer");
    a_window_off: assert property (
        win_r && sel_a_s && !sel_b_s |=> wd_cnt_r == '0)
        else $error("watchdog not disabled by straps");
    a_ratio_div: assert property (
        sel_a_s && sel_b_s |-> fast_lim == period_r / 64)
        else $error("fast limit ratio wrong");
    a_xsel_clear: assert property (
        !win_r && $changed(xsel_s) |=> wd_cnt_r == '0)
        else $error("select change did not clear timer");
    a_kick_ignored: assert property (
        !o_reset_n |-> !wd_fault && !kick_ok)
        else $error("kick acted during reset");

    c_basic_timeout: cover property (
        !win_r && wd_fault ##1 !o_reset_n);
    c_fast_fault: cover property (win_r && ev[EV_FAST]);
    c_slow_fault: cover property (win_r && ev[EV_TIMEOUT]);
    c_manual_reset: cover property (
        !mr_n_s ##1 mr_n_s [*4] ##1 o_reset_n);
endmodule : wrs_supervisor

// *** src/wrs_sync.sv ***
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module wrs_sync #(
    parameter int         P_W    = 1,
    parameter logic [P_W-1:0] P_INIT = '0
) (
    input  wire logic           i_ref_clk,
    input  wire logic           i_rst_b,
    input  wire logic [P_W-1:0] i_async,
    output logic      [P_W-1:0] o_sync
);
    logic [P_W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            meta_r <= P_INIT;
            o_sync <= P_INIT;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : wrs_sync

// *** tb/wrs_host_model.sv ***
// host processor model that services the watchdog kick pin
`timescale 1ns/1ps
module wrs_host_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    input  wire logic [15:0] i_gap,
    output logic             o_kick = 1'h1
);
    logic [15:0] cnt_r = 16'h1;
    // a host held in reset does no servicing; a zero gap stops it,
    // which is how the bench provokes a late-service fault
    always @(posedge i_ref_clk) begin
        if (i_reset_n !== 1'h1 || i_gap == 16'h0) begin
            cnt_r  <= 16'h1;
            o_kick <= 1'h1;
        end else if (cnt_r >= i_gap) begin
            cnt_r  <= 16'h1;
            o_kick <= 1'h0; // one falling edge every gap cycles
        end else begin
            cnt_r  <= cnt_r + 16'h1;
            if (cnt_r >= 16'h2) o_kick <= 1'h1;
        end
    end
endmodule : wrs_host_model

// *** tb/wrs_supervisor_test.sv ***
// self-checking bench for the watchdog reset supervisor
`timescale 1ns/1ps
module wrs_supervisor_test;
    import wrs_pkg::*;
    logic        i_ref_clk = 1'h0;
    logic        i_rst_b = 1'h0;
    logic        i_kick_input;
    logic [2:0]  flt = 3'h0;
    logic        i_extended_period_select = 1'h0;
    logic        i_ratio_select_a = 1'h0;
    logic        i_ratio_select_b = 1'h0;
    logic        o_reset_n, o_irq, o_s_axi_awready, o_s_axi_wready;
    logic        o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
    logic [31:0] o_s_axi_rdata, d;
    logic [31:0] i_s_axi_wdata = 32'h0;
    logic [7:0]  i_s_axi_awaddr = 8'h0, i_s_axi_araddr = 8'h0;
    logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0;
    // both response readies stay high, so no task toggles them
    logic        i_s_axi_bready = 1'h1, i_s_axi_arvalid = 1'h0;
    logic        i_s_axi_rready = 1'h1;
    logic [15:0] gap = 16'h0;
    int          failures = 0, n_compared = 0, w, hi;
    logic [7:0]  ro [5] = '{OFS_CTRL, OFS_HOLD, OFS_PERIOD, OFS_STATUS,
                            OFS_IRQ_EN};
    logic [31:0] rv [5] = '{32'h0, 32'hc8, 32'h3e8, 32'h2, 32'h0};
    logic [1:0]  ab [5] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h2};
    logic [15:0] kg [5] = '{16'h6, 16'h6, 16'h3, 16'h3, 16'h3};
    logic        kf [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};

    wrs_supervisor dut_u (
        .i_ref_clk, .i_rst_b, .i_kick_input,
        .i_manual_reset_n(~flt[0]), .i_supply_low(flt[1]),
        .i_ext_monitor_low(flt[2]), .i_extended_period_select,
        .i_ratio_select_a, .i_ratio_select_b, .o_reset_n, .o_irq,
        .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
        .i_s_axi_wdata, .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid,
        .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
        .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
        .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
        .o_s_axi_rvalid, .i_s_axi_rready
    );
    wrs_host_model host_u (
        .i_ref_clk, .i_reset_n(o_reset_n), .i_gap(gap),
        .o_kick(i_kick_input)
    );

    always #20 i_ref_clk = ~i_ref_clk;

    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_n(string nm, int lo, int hb, int got);
        n_compared++;
        if (got < lo || got > hb) begin
            failures++;
            $display("wrong value %s expected %0d..%0d seen %0d",
                     nm, lo, hb, got);
        end
    endtask : chk_n

    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic hang(string nm);
        failures++;
        $display("wrong value %s expected answer seen timeout", nm);
        report_and_stop();
    endtask : hang

    // handshakes are judged at the falling edge, so that what is seen
    // is exactly what the next rising edge will sample
    task automatic wr(logic [7:0] a, logic [31:0] v, logic [1:0] er);
        bit         ha, hw, hb;
        logic [1:0] rs;
        i_s_axi_awaddr  <= a;
        i_s_axi_wdata   <= v;
        i_s_axi_awvalid <= 1'h1;
        i_s_axi_wvalid  <= 1'h1;
        for (int n = 0; n < 50; n++) begin
            @(negedge i_ref_clk);
            ha = i_s_axi_awvalid && o_s_axi_awready;
            hw = i_s_axi_wvalid && o_s_axi_wready;
            hb = o_s_axi_bvalid === 1'h1;
            rs = o_s_axi_bresp;
            @(posedge i_ref_clk);
            if (ha) i_s_axi_awvalid <= 1'h0;
            if (hw) i_s_axi_wvalid <= 1'h0;
            if (hb) begin
                chk("bresp", {30'h0, er}, {30'h0, rs});
                return;
            end
        end
        hang("write");
    endtask : wr

    task automatic rd(logic [7:0] a, logic [1:0] er);
        bit         ha, hb;
        logic [1:0] rs;
        i_s_axi_araddr  <= a;
        i_s_axi_arvalid <= 1'h1;
        for (int n = 0; n < 50; n++) begin
            @(negedge i_ref_clk);
            ha = i_s_axi_arvalid && o_s_axi_arready;
            hb = o_s_axi_rvalid === 1'h1;
            rs = o_s_axi_rresp;
            d  = o_s_axi_rdata;
            @(posedge i_ref_clk);
            if (ha) i_s_axi_arvalid <= 1'h0;
            if (hb) begin
                chk("rresp", {30'h0, er}, {30'h0, rs});
                return;
            end
        end
        hang("read");
    endtask : rd

    // hc: high cycles before a low pulse, wd: its length, 0 if none
    task automatic pulse(int lim, output int wd, output int hc);
        bit ok;
        ok = 1'b0;
        wd = 0;
        hc = 0;
        for (int n = 0; n < lim + 1000; n++) begin
            @(negedge i_ref_clk);
            if (o_reset_n === 1'h0) wd++;
            else if (wd > 0 || hc >= lim) begin
                ok = 1'b1;
                break;
            end else begin
                hc++;
            end
        end
        // a reset that never releases must not pass silently
        if (!ok) hang("reset pulse");
        @(posedge i_ref_clk);
    endtask : pulse

    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_rst_b <= 1'h1;
        gap     <= 16'd20;
        pulse(1, w, hi);
        foreach (ro[k]) begin
            rd(ro[k], RESP_OKAY);
            chk("reset value", rv[k], d);
        end
        rd(8'h1c, RESP_SLVERR);
        wr(8'h1c, 32'h1, RESP_SLVERR);
        wr(OFS_HOLD, 32'h4, RESP_OKAY);
        wr(OFS_PERIOD, 32'h40, RESP_OKAY);
        $display("test registers done");
        for (int k = 0; k < 3; k++) begin
            flt <= 3'h1 << k;
            repeat (8) @(posedge i_ref_clk);
            @(negedge i_ref_clk);
            chk("reset low", 32'h0, {31'h0, o_reset_n});
            @(posedge i_ref_clk);
            flt <= 3'h0;
            pulse(0, w, hi);
            chk_n("hold after cause", 4, 8, w);
        end
        rd(OFS_IRQ_STAT, RESP_OKAY);
        chk("cause status", 32'h1, d);
        chk("irq masked", 32'h0, {31'h0, o_irq});
        wr(OFS_IRQ_EN, 32'h7, RESP_OKAY);
        repeat (2) @(posedge i_ref_clk);
        chk("irq raised", 32'h1, {31'h0, o_irq});
        wr(OFS_IRQ_CLR, 32'h7, RESP_OKAY);
        repeat (2) @(posedge i_ref_clk);
        chk("irq cleared", 32'h0, {31'h0, o_irq});
        $display("test causes done");
        gap <= 16'h0;
        pulse(300, w, hi);
        chk_n("watchdog pulse", 4, 4, w);
        pulse(300, w, hi);
        chk_n("basic period", 63, 65, hi);
        gap <= 16'd20;
        rd(OFS_IRQ_STAT, RESP_OKAY);
        chk("timeout status", 32'h2, d);
        wr(OFS_IRQ_CLR, 32'h7, RESP_OKAY);
        wr(OFS_PERIOD, 32'h0, RESP_OKAY);
        gap <= 16'h0;
        pulse(300, w, hi);
        chk_n("disabled", 0, 0, w);
        gap <= 16'd20;
        wr(OFS_PERIOD, 32'h40, RESP_OKAY);
        i_extended_period_select <= 1'h1;
        gap <= 16'h0;
        pulse(9000, w, hi);
        chk_n("extended period", 8192, 8200, hi);
        chk_n("extended pulse", 4, 4, w);
        i_extended_period_select <= 1'h0;
        gap <= 16'd20;
        wr(OFS_IRQ_CLR, 32'h7, RESP_OKAY);
        $display("test basic done");
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        // kicks pause while the straps move, so each row starts clean
        for (int k = 0; k < 5; k++) begin
            {i_ratio_select_a, i_ratio_select_b} <= ab[k];
            gap <= 16'h0;
            @(posedge i_ref_clk);
            gap <= kg[k];
            repeat (100) @(posedge i_ref_clk);
            gap <= 16'd20;
            repeat (30) @(posedge i_ref_clk);
            rd(OFS_IRQ_STAT, RESP_OKAY);
            chk("fast fault", {29'h0, kf[k], 2'h0}, d);
            wr(OFS_IRQ_CLR, 32'h7, RESP_OKAY);
        end
        {i_ratio_select_a, i_ratio_select_b} <= 2'h0;
        gap <= 16'h0;
        pulse(300, w, hi);
        chk_n("slow fault pulse", 4, 4, w);
        pulse(300, w, hi);
        chk_n("window start", 63, 66, hi);
        rd(OFS_IRQ_STAT, RESP_OKAY);
        chk("slow status", 32'h2, d);
        $display("test window done");
        report_and_stop();
    end
endmodule : wrs_supervisor_test
